// ---- core/tfeg_pkg.sv ----
package tfeg_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_SWEVT = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam logic [7:0] OFS_CAPVAL0 = 8'h1c;
  localparam int NCH = 4;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] FLAGS_MASK = 16'h1eff;
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] CFG_MASK = 16'h003f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_UPD = 0;
  localparam int B_CC0 = 1;
  localparam int B_CMT = 5;
  localparam int B_TRG = 6;
  localparam int B_BRK = 7;
  localparam int B_OC0 = 9;
  localparam int B_CFG_INPUT0 = 0;
  localparam int B_CFG_PAUSE = 4;
  localparam int B_CFG_POE = 5;

  typedef struct packed {
    logic update;
    logic [NCH-1:0] capcomp;
    logic commutation;
    logic trigger_edge;
    logic trigger_level;
    logic break_active;
  } tfeg_hw_evt_t;

  typedef struct packed {
    logic update;
    logic prescaler_clear;
    logic commutation_load;
    logic [NCH-1:0] capture_strobe;
  } tfeg_sw_evt_t;
endpackage

// ---- core/tfeg_flag.sv ----
`timescale 1ns/100ps
// Sticky flag, hardware set beats software clear
module tfeg_flag (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  // State
  output logic flag_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end
endmodule // tfeg_flag

// ---- core/tfeg_top.sv ----
`timescale 1ns/100ps
// What this block does
// - Ch0 overcapture on capture while flag set
// - Ch1-3 overcapture flags behave alike
// - Break flag set on break, guarded clear
// - Trigger flag; pause mode counts both edges
// - Commutation flag set, software clears it
// - Ch0 flag on capture or compare
// - Reading ch0 capture value clears flag in input mode
// - Ch1-3 capture/compare flags behave alike
// - Update flag set per update event
// - Reserved bits kept at reset value
// - Event bits write-only, self-clearing
// - Break generate clears output enable, sets flag
// - Trigger generate sets trigger flag
// - Commutation generate loads channel controls
// - Channel generate bits make channel events
// - Software capture latches counter into ch0 value only, may overcapture
// - Update generate clears counter and prescaler
// - Interrupt only when enable bit set
module tfeg_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer core events
  input wire tfeg_pkg::tfeg_hw_evt_t hw_evt,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] irq_enable,
  // Software event strobes
  output tfeg_pkg::tfeg_sw_evt_t sw_evt,
  // Status
  output logic [15:0] flags,
  output logic primary_output_enable,
  output logic irq
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic hit_flags;
  logic hit_swevt;
  logic hit_cfg;
  logic hit_cap;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_flags = paddr == tfeg_pkg::OFS_FLAGS;
  assign hit_swevt = paddr == tfeg_pkg::OFS_SWEVT;
  assign hit_cfg = paddr == tfeg_pkg::OFS_CONFIG;
  assign hit_cap = paddr == tfeg_pkg::OFS_CAPVAL0;
  // Zero wait state: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~(hit_flags | hit_swevt | hit_cfg | hit_cap);

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // Bits 3:0 channel input mode, 4 pause mode, 5 output enable
  logic [15:0] cfg_q;
  logic brk_gen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= tfeg_pkg::CONFIG_RST;
    end else if (brk_gen) begin
      cfg_q[tfeg_pkg::B_CFG_POE] <= 1'b0;
    end else if (wr && hit_cfg) begin
      cfg_q <= pwdata[15:0] & tfeg_pkg::CFG_MASK;
    end
  end
  assign primary_output_enable = cfg_q[tfeg_pkg::B_CFG_POE];

  // ----------------------------------------
  // Software event pulses
  // ----------------------------------------
  // Never stored; reads back zero so the bits appear self-clearing
  logic [15:0] gen;
  assign gen = (wr && hit_swevt) ? pwdata[15:0] : 16'h0000;
  assign brk_gen = gen[tfeg_pkg::B_BRK];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_evt <= '0;
    end else begin
      sw_evt.update <= gen[tfeg_pkg::B_UPD];
      sw_evt.prescaler_clear <= gen[tfeg_pkg::B_UPD];
      sw_evt.commutation_load <= gen[tfeg_pkg::B_CMT];
      sw_evt.capture_strobe <= gen[tfeg_pkg::B_CC0 +: tfeg_pkg::NCH];
    end
  end

  // ----------------------------------------
  // Flag set and clear terms
  // ----------------------------------------
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic trig_prev_q;
  logic trig_evt;
  logic [tfeg_pkg::NCH-1:0] cc_evt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= hw_evt.trigger_level;
    end
  end
  // Pause mode: any level change is an event
  assign trig_evt = cfg_q[tfeg_pkg::B_CFG_PAUSE] ? (hw_evt.trigger_level ^ trig_prev_q)
    : hw_evt.trigger_edge;
  assign cc_evt = hw_evt.capcomp | gen[tfeg_pkg::B_CC0 +: tfeg_pkg::NCH];

  always_comb begin
    set_v = 16'h0000;
    clr_v = 16'h0000;
    set_v[tfeg_pkg::B_UPD] = hw_evt.update | gen[tfeg_pkg::B_UPD];
    set_v[tfeg_pkg::B_CMT] = hw_evt.commutation | gen[tfeg_pkg::B_CMT];
    set_v[tfeg_pkg::B_TRG] = trig_evt | gen[tfeg_pkg::B_TRG];
    set_v[tfeg_pkg::B_BRK] = hw_evt.break_active | brk_gen;
    if (wr && hit_flags) begin
      clr_v = ~pwdata[15:0] & tfeg_pkg::FLAGS_MASK;
      // Break flag cannot be cleared while the input holds it
      if (hw_evt.break_active) begin
        clr_v[tfeg_pkg::B_BRK] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic [15:0] flag_q;
  logic cap_rd;
  assign cap_rd = rd & hit_cap;
  for (genvar b = 0; b <= tfeg_pkg::B_BRK; b++) begin : g_misc
    if (b == tfeg_pkg::B_UPD || b == tfeg_pkg::B_CMT || b == tfeg_pkg::B_TRG || b == tfeg_pkg::B_BRK) begin : g_on
      tfeg_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(set_v[b]),
        .clr_i(clr_v[b]),
        .flag_q(flag_q[b])
      );
    end
  end
  logic [15:0] cap0_q;
  for (genvar c = 0; c < tfeg_pkg::NCH; c++) begin : g_ch
    logic is_in;
    logic cc_clr;
    assign is_in = cfg_q[tfeg_pkg::B_CFG_INPUT0 + c];
    // Reading capture value clears only channel 0 and only in input mode
    assign cc_clr = clr_v[tfeg_pkg::B_CC0 + c] | ((c == 0) & is_in & cap_rd);
    tfeg_flag u_cc (
      .pclk(pclk),
      .presetn(presetn),
      .set_i(cc_evt[c]),
      .clr_i(cc_clr),
      .flag_q(flag_q[tfeg_pkg::B_CC0 + c])
    );
    tfeg_flag u_oc (
      .pclk(pclk),
      .presetn(presetn),
      .set_i(is_in & cc_evt[c] & flag_q[tfeg_pkg::B_CC0 + c]),
      .clr_i(clr_v[tfeg_pkg::B_OC0 + c]),
      .flag_q(flag_q[tfeg_pkg::B_OC0 + c])
    );
  end
  assign flag_q[tfeg_pkg::B_OC0 - 1] = 1'b0;
  assign flag_q[15:tfeg_pkg::B_OC0 + tfeg_pkg::NCH] = '0;
  assign flags = flag_q;

  // Channel 0 capture value on any channel 0 capture in input mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap0_q <= 16'h0000;
    end else if (cc_evt[0] && cfg_q[tfeg_pkg::B_CFG_INPUT0]) begin
      cap0_q <= counter_value;
    end
  end

  assign irq = |(flag_q[tfeg_pkg::B_BRK:tfeg_pkg::B_UPD] & irq_enable[tfeg_pkg::B_BRK:tfeg_pkg::B_UPD]);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (hit_flags) prdata = {16'h0000, flag_q};
      else if (hit_cfg) prdata = {16'h0000, cfg_q};
      else if (hit_cap) prdata = {16'h0000, cap0_q};
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_upd_set;
    @(posedge pclk) disable iff (!presetn) hw_evt.update |=> flag_q[tfeg_pkg::B_UPD];
  endproperty
  a_upd_set: assert property (p_upd_set) else $error("update flag not set");
  property p_brk_gen;
    @(posedge pclk) disable iff (!presetn) brk_gen |=> !primary_output_enable && flag_q[tfeg_pkg::B_BRK];
  endproperty
  a_brk_gen: assert property (p_brk_gen) else $error("break generate failed");
  property p_brk_hold;
    @(posedge pclk) disable iff (!presetn) hw_evt.break_active |=> flag_q[tfeg_pkg::B_BRK];
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break flag lost");
  property p_trg_gen;
    @(posedge pclk) disable iff (!presetn) gen[tfeg_pkg::B_TRG] |=> flag_q[tfeg_pkg::B_TRG];
  endproperty
  a_trg_gen: assert property (p_trg_gen) else $error("trigger flag not set");
  property p_cmt;
    @(posedge pclk) disable iff (!presetn) gen[tfeg_pkg::B_CMT] |=> sw_evt.commutation_load && flag_q[tfeg_pkg::B_CMT];
  endproperty
  a_cmt: assert property (p_cmt) else $error("commutation event missing");
  property p_over0;
    @(posedge pclk) disable iff (!presetn)
      cfg_q[tfeg_pkg::B_CFG_INPUT0] && flag_q[tfeg_pkg::B_CC0] && cc_evt[0] |=> flag_q[tfeg_pkg::B_OC0];
  endproperty
  a_over0: assert property (p_over0) else $error("overcapture not set");
  property p_caprd;
    @(posedge pclk) disable iff (!presetn)
      cap_rd && cfg_q[tfeg_pkg::B_CFG_INPUT0] && !cc_evt[0] |=> !flag_q[tfeg_pkg::B_CC0];
  endproperty
  a_caprd: assert property (p_caprd) else $error("capture read did not clear");
  property p_capval;
    @(posedge pclk) disable iff (!presetn) cfg_q[tfeg_pkg::B_CFG_INPUT0] && cc_evt[0] |=> cap0_q == $past(counter_value);
  endproperty
  a_capval: assert property (p_capval) else $error("capture value wrong");
  property p_upd_gen;
    @(posedge pclk) disable iff (!presetn)
      gen[tfeg_pkg::B_UPD] |=> sw_evt.update ##1 (!sw_evt.update || gen[tfeg_pkg::B_UPD]);
  endproperty
  a_upd_gen: assert property (p_upd_gen) else $error("update strobe wrong");

  // ----------------------------------------
  // Event strobe sequences
  // ----------------------------------------
  // Strobes last one cycle so the core never sees a held request
  sequence s_cmt_strobe;
    sw_evt.commutation_load ##1 !sw_evt.commutation_load;
  endsequence
  sequence s_upd_strobes;
    (sw_evt.update && sw_evt.prescaler_clear) ##1 (!sw_evt.update && !sw_evt.prescaler_clear);
  endsequence
  property p_cmt_pulse;
    @(posedge pclk) disable iff (!presetn)
      gen[tfeg_pkg::B_CMT] |=> s_cmt_strobe;
  endproperty
  a_cmt_pulse: assert property (p_cmt_pulse) else $error("commutation strobe not single");
  property p_upd_pulse;
    @(posedge pclk) disable iff (!presetn)
      gen[tfeg_pkg::B_UPD] |=> s_upd_strobes;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update strobes not single");

  // ----------------------------------------
  // Flag write and clear checks
  // ----------------------------------------
  property p_keep_one;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_flags && pwdata[tfeg_pkg::B_UPD] && flag_q[tfeg_pkg::B_UPD] |=> flag_q[tfeg_pkg::B_UPD];
  endproperty
  a_keep_one: assert property (p_keep_one) else $error("write one cleared flag");
  property p_brk_clear;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_flags && !pwdata[tfeg_pkg::B_BRK] && !hw_evt.break_active |=> !flag_q[tfeg_pkg::B_BRK];
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("break flag not cleared");
  property p_cmt_set;
    @(posedge pclk) disable iff (!presetn)
      hw_evt.commutation |=> flag_q[tfeg_pkg::B_CMT];
  endproperty
  a_cmt_set: assert property (p_cmt_set) else $error("commutation flag not set");
  property p_trg_edge;
    @(posedge pclk) disable iff (!presetn)
      !cfg_q[tfeg_pkg::B_CFG_PAUSE] && hw_evt.trigger_edge |=> flag_q[tfeg_pkg::B_TRG];
  endproperty
  a_trg_edge: assert property (p_trg_edge) else $error("trigger edge missed");
  property p_trg_pause;
    @(posedge pclk) disable iff (!presetn)
      cfg_q[tfeg_pkg::B_CFG_PAUSE] && $changed(hw_evt.trigger_level) |=> flag_q[tfeg_pkg::B_TRG];
  endproperty
  a_trg_pause: assert property (p_trg_pause) else $error("pause trigger missed");
  property p_trg_quiet;
    @(posedge pclk) disable iff (!presetn)
      !cfg_q[tfeg_pkg::B_CFG_PAUSE] && !hw_evt.trigger_edge && !gen[tfeg_pkg::B_TRG] && !flag_q[tfeg_pkg::B_TRG]
      |=> !flag_q[tfeg_pkg::B_TRG];
  endproperty
  a_trg_quiet: assert property (p_trg_quiet) else $error("trigger flag set without event");
  property p_caprd_keep;
    @(posedge pclk) disable iff (!presetn)
      cap_rd && !cfg_q[tfeg_pkg::B_CFG_INPUT0] && flag_q[tfeg_pkg::B_CC0] |=> flag_q[tfeg_pkg::B_CC0];
  endproperty
  a_caprd_keep: assert property (p_caprd_keep) else $error("output mode read cleared flag");
  property p_swevt_zero;
    @(posedge pclk) disable iff (!presetn)
      rd && hit_swevt |-> prdata == 32'h0000_0000;
  endproperty
  a_swevt_zero: assert property (p_swevt_zero) else $error("event register read not zero");
  property p_cfg_rsv;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_cfg |=> (cfg_q & ~tfeg_pkg::CFG_MASK) == 16'h0000;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("reserved config bits stored");
  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
      irq_enable[tfeg_pkg::B_BRK:tfeg_pkg::B_UPD] == 8'h00 |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enable");
  property p_irq_on;
    @(posedge pclk) disable iff (!presetn)
      irq_enable[tfeg_pkg::B_UPD] && flag_q[tfeg_pkg::B_UPD] |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled irq missing");

  // ----------------------------------------
  // Per-channel flag checks
  // ----------------------------------------
  // Channels 1 to 3 get the loop checks of channel 0; the capture read and value checks are channel 0 only
  for (genvar c = 0; c < tfeg_pkg::NCH; c++) begin : g_chk
    property p_cc_hw;
      @(posedge pclk) disable iff (!presetn)
        hw_evt.capcomp[c] |=> flag_q[tfeg_pkg::B_CC0 + c];
    endproperty
    a_cc_hw: assert property (p_cc_hw) else $error("capture/compare flag not set");
    property p_cc_gen;
      @(posedge pclk) disable iff (!presetn)
        gen[tfeg_pkg::B_CC0 + c] |=> sw_evt.capture_strobe[c] && flag_q[tfeg_pkg::B_CC0 + c];
    endproperty
    a_cc_gen: assert property (p_cc_gen) else $error("channel generate failed");
    property p_oc_set;
      @(posedge pclk) disable iff (!presetn)
        cfg_q[tfeg_pkg::B_CFG_INPUT0 + c] && cc_evt[c] && flag_q[tfeg_pkg::B_CC0 + c] |=> flag_q[tfeg_pkg::B_OC0 + c];
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("channel overcapture not set");
    property p_oc_out;
      @(posedge pclk) disable iff (!presetn)
        !cfg_q[tfeg_pkg::B_CFG_INPUT0 + c] && !flag_q[tfeg_pkg::B_OC0 + c] |=> !flag_q[tfeg_pkg::B_OC0 + c];
    endproperty
    a_oc_out: assert property (p_oc_out) else $error("overcapture in output mode");
  end
endmodule // tfeg_top

// ---- bench/tfeg_tb.sv ----
`timescale 1ns/100ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, primary_output_enable, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [8:0] hw_bits;
  logic [15:0] counter_value, irq_enable, flags;
  logic err_q;
  tfeg_pkg::tfeg_sw_evt_t sw_evt;
  int num_errors = 0;
  int total_checks = 0;

  tfeg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_evt(tfeg_pkg::tfeg_hw_evt_t'(hw_bits)), .counter_value(counter_value),
    .irq_enable(irq_enable), .sw_evt(sw_evt), .flags(flags),
    .primary_output_enable(primary_output_enable), .irq(irq));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Leading edge keeps back-to-back calls from driving psel twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends once pready is seen high; only a stalled wait is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd_q, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    hw_bits[b] <= 1'b1;
    @(posedge pclk);
    hw_bits[b] <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    hw_bits = 9'h000; counter_value = 16'h0abc; irq_enable = 16'h0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h0, "flags reset");
    rd(8'h14, 32'h0, "swevt reset");
    $display("test reset done");
    pulse(8);
    rd(8'h10, 32'h1, "update flag");
    chk("flags port", flags, 32'h1);
    @(posedge pclk);
    irq_enable <= 16'h0001;
    @(posedge pclk);
    #1 chk("irq enabled", irq, 32'h1);
    @(posedge pclk);
    irq_enable <= 16'h0000;
    @(posedge pclk);
    #1 chk("irq masked", irq, 32'h0);
    wr(8'h10, 32'hffff);
    rd(8'h10, 32'h1, "write one keeps");
    wr(8'h10, 32'h1efe);
    rd(8'h10, 32'h0, "write zero clears");
    fork
      wr(8'h10, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        hw_bits[8] <= 1'b1;
        @(posedge pclk);
        hw_bits[8] <= 1'b0;
      end
    join
    rd(8'h10, 32'h1, "set beats clear");
    wr(8'h10, 32'h0);
    pulse(3);
    pulse(2);
    rd(8'h10, 32'h60, "cmt and trg");
    wr(8'h10, 32'h0);
    $display("test flags done");
    // Level edges only count in pause mode
    @(posedge pclk);
    hw_bits[1] <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(8'h10, 32'h0, "level no pause");
    @(posedge pclk);
    hw_bits[1] <= 1'b0;
    wr(8'h18, 32'h10);
    @(posedge pclk);
    hw_bits[1] <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(8'h10, 32'h40, "pause rise");
    wr(8'h10, 32'h0);
    @(posedge pclk);
    hw_bits[1] <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(8'h10, 32'h40, "pause fall");
    wr(8'h10, 32'h0);
    @(posedge pclk);
    hw_bits[0] <= 1'b1;
    @(posedge pclk);
    rd(8'h10, 32'h80, "break set");
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h80, "break clear refused");
    @(posedge pclk);
    hw_bits[0] <= 1'b0;
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h0, "break cleared");
    $display("test trigger break done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h18, (m == 0) ? 32'hf : 32'h0);
        pulse(4 + c);
        pulse(4 + c);
        rd(8'h10, (32'h2 << c) | ((m == 0) ? (32'h200 << c) : 32'h0), "cc overcapture");
        wr(8'h10, 32'h0);
      end
    end
    $display("test capture done");
    wr(8'h18, 32'h1);
    @(posedge pclk);
    counter_value <= 16'h5a3c;
    wr(8'h14, 32'h2);
    rd(8'h1c, 32'h5a3c, "capture value");
    rd(8'h10, 32'h0, "read clears cc0");
    wr(8'h14, 32'h2);
    wr(8'h14, 32'h2);
    rd(8'h10, 32'h202, "sw overcapture");
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h0);
    @(posedge pclk);
    counter_value <= 16'h0f0f;
    wr(8'h14, 32'h2);
    rd(8'h1c, 32'h5a3c, "output no capture");
    rd(8'h10, 32'h2, "output read keeps cc0");
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h2f);
    #1 chk("poe on", primary_output_enable, 32'h1);
    for (int b = 0; b < 8; b++) begin
      wr(8'h14, 32'h1 << b);
      #1 chk("sw strobe", sw_evt, (b == 0) ? 32'h60 : (b == 5) ? 32'h10 :
        (b < 5) ? (32'h1 << (b - 1)) : 32'h0);
      rd(8'h14, 32'h0, "swevt reads zero");
      rd(8'h10, 32'h1 << b, "sw flag");
      wr(8'h10, 32'h0);
    end
    chk("poe off", primary_output_enable, 32'h0);
    $display("test sw events done");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", err_q, 32'h1);
    chk("unmapped data", rd_q, 32'h0);
    $display("test unmapped done");
    report_and_stop;
  end
endmodule // tb
